/* File: rtl/can_txq_ctrl.sv */
// transmit queue control, status and head address registers
// How it works
// [R01] writing reset bit resets queue, then self-clears
// [R02] host polls reset bit until it reads zero
// [R03] reset bit held in configuration, cleared leaving it
// [R04] send request set by host, cleared after all sent
// [R05] writing zero while set requests message abort
// [R06] send request clears only on completion, abort, reset
// [R07] head increment advances head by one slot
// [R08] transmit direction bit always reads one
// [R09] three separate interrupt enables, one enables
// [R10] five-bit index of next message to transmit
// [R11] aborted bit: last message aborted, else zero
// [R12] lost arbitration bit set when arbitration lost
// [R13] transmit error bit set on bus error
// [R14] three status bits cleared on request or written zero
// [R15] three status bits set only at completion or abort, reset clears
// [R16] sticky flag when attempts exhausted, host clears
// [R17] empty flag reads one when queue holds nothing
// [R18] not-full flag reads one when slot free
// [R19] head address register gives next write address
// [R20] host reads head address only outside configuration
// [R21] retry field: none, three, or unlimited retries
// [R22] empty and not-full follow pointers and depth
module can_txq_ctrl (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic config_mode_in,
    input wire logic global_retry_enable_in,
    input wire logic [4:0] queue_depth_field_in,
    input wire logic [31:0] ram_base_in,
    input wire logic [7:0] slot_bytes_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [1:0] reg_sel_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic tx_success_in,
    input wire logic tx_lost_arb_in,
    input wire logic tx_bus_err_in,
    input wire logic tx_aborted_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic tx_pending_out,
    output logic abort_request_out,
    output logic [4:0] tail_index_out,
    output logic [2:0] irq_enabled_events_out
);

    can_txq_pkg::queue_state_t state;
    can_txq_pkg::queue_state_t next_state;

    logic [1:0] retry_attempts_field;
    logic attempts_exhausted_irq_enable;
    logic queue_empty_irq_enable;
    logic queue_not_full_irq_enable;
    logic send_request_bit;
    logic abort_pending;
    logic aborted_status;
    logic lost_arbitration_status;
    logic transmit_error_status;
    logic attempts_exhausted_flag;
    logic acc_lost_arb;
    logic acc_bus_err;
    logic [2:0] fail_count;
    logic [31:0] queue_head_address;

    logic [4:0] head_index;
    logic [4:0] next_transmit_index;
    logic queue_empty_flag;
    logic queue_not_full_flag;
    logic last_one;

    logic wr_control;
    logic wr_status;
    logic queue_reset_bit;
    logic head_increment;
    logic request_set;
    logic request_abort;
    logic attempt_failed;
    logic exhausted;
    logic msg_done;
    logic msg_abort;

    function automatic logic field_is(input logic [31:0] word, input int pos);
        field_is = word[pos];
    endfunction

    assign wr_control = reg_write_in && (reg_sel_in == can_txq_pkg::SEL_CONTROL);
    assign wr_status = reg_write_in && (reg_sel_in == can_txq_pkg::SEL_STATUS);
    assign queue_reset_bit = (state == can_txq_pkg::Q_RESET);
    // commits are refused while the queue is being reset
    assign head_increment = wr_control && !queue_reset_bit
        && field_is(reg_wdata_in, can_txq_pkg::CTL_HEAD_INCREMENT);
    assign request_set = wr_control && !queue_reset_bit && !send_request_bit
        && field_is(reg_wdata_in, can_txq_pkg::CTL_SEND_REQUEST);
    assign request_abort = wr_control && send_request_bit
        && !field_is(reg_wdata_in, can_txq_pkg::CTL_SEND_REQUEST); // [R05]
    assign attempt_failed = send_request_bit && (tx_lost_arb_in || tx_bus_err_in);

    // retries only apply when enabled globally; otherwise one try per message
    always_comb begin
        exhausted = 1'b0;
        if (attempt_failed) begin
            if (!global_retry_enable_in || retry_attempts_field == can_txq_pkg::RETRY_NONE) begin
                exhausted = (fail_count + 3'h1) >= can_txq_pkg::FAILS_NO_RETRY; // [R21]
            end else if (retry_attempts_field == can_txq_pkg::RETRY_THREE) begin
                exhausted = (fail_count + 3'h1) >= can_txq_pkg::FAILS_THREE_RETRY; // [R21]
            end
        end
    end

    assign msg_done = send_request_bit && tx_success_in;
    assign msg_abort = send_request_bit && (tx_aborted_in || exhausted);

    txq_pointers u_pointers (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .clear_in(queue_reset_bit),
        .push_in(head_increment),
        .pop_in(msg_done),
        .depth_field_in(queue_depth_field_in),
        .head_index_out(head_index),
        .tail_index_out(next_transmit_index),
        .empty_out(queue_empty_flag),
        .not_full_out(queue_not_full_flag),
        .last_one_out(last_one)
    );

    // queue reset sequencing
    always_comb begin
        next_state = state;
        if (config_mode_in) begin
            next_state = can_txq_pkg::Q_RESET; // [R03]
        end else if (state == can_txq_pkg::Q_RESET) begin
            next_state = can_txq_pkg::Q_RUN; // [R01] [R03]
        end else if (wr_control && field_is(reg_wdata_in, can_txq_pkg::CTL_QUEUE_RESET)) begin
            next_state = can_txq_pkg::Q_RESET; // [R01]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state <= can_txq_pkg::Q_RESET;
        end else begin
            state <= next_state;
        end
    end

    // host-writable control fields
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            retry_attempts_field <= can_txq_pkg::RETRY_FIELD_RESET;
            attempts_exhausted_irq_enable <= 1'b0;
            queue_empty_irq_enable <= 1'b0;
            queue_not_full_irq_enable <= 1'b0;
        end else if (wr_control) begin
            // retry policy must not change under a message in flight
            if (config_mode_in) begin
                retry_attempts_field <= reg_wdata_in[can_txq_pkg::CTL_RETRY_LSB +: 2];
            end
            attempts_exhausted_irq_enable <= reg_wdata_in[can_txq_pkg::CTL_ATTEMPTS_IE]; // [R09]
            queue_empty_irq_enable <= reg_wdata_in[can_txq_pkg::CTL_EMPTY_IE]; // [R09]
            queue_not_full_irq_enable <= reg_wdata_in[can_txq_pkg::CTL_NOT_FULL_IE]; // [R09]
        end
    end

    // send request and abort request
    always_ff @(posedge mclk_in) begin
        if (rst_in || queue_reset_bit) begin
            send_request_bit <= 1'b0; // [R06]
            abort_pending <= 1'b0;
        end else begin
            if (msg_abort || (msg_done && last_one)) begin
                send_request_bit <= 1'b0; // [R04] [R06]
            end else if (request_set) begin
                send_request_bit <= 1'b1; // [R04]
            end
            // the bit itself stays set until the abort really happens
            if (msg_abort || (msg_done && last_one)) begin
                abort_pending <= 1'b0;
            end else if (request_abort) begin
                abort_pending <= 1'b1; // [R05]
            end
        end
    end

    // failed attempt bookkeeping, folded into status only at message end
    always_ff @(posedge mclk_in) begin
        if (rst_in || queue_reset_bit || msg_done || msg_abort || request_set) begin
            fail_count <= 3'h0;
            acc_lost_arb <= 1'b0;
            acc_bus_err <= 1'b0;
        end else if (attempt_failed) begin
            if (fail_count != 3'h7) begin
                fail_count <= fail_count + 3'h1;
            end
            acc_lost_arb <= acc_lost_arb || tx_lost_arb_in;
            acc_bus_err <= acc_bus_err || tx_bus_err_in;
        end
    end

    // message outcome status; an outcome in the clearing cycle wins
    always_ff @(posedge mclk_in) begin
        if (rst_in || queue_reset_bit) begin
            aborted_status <= 1'b0; // [R15]
            lost_arbitration_status <= 1'b0;
            transmit_error_status <= 1'b0;
        end else if (msg_done || msg_abort) begin
            aborted_status <= msg_abort; // [R11] [R15]
            lost_arbitration_status <= acc_lost_arb || tx_lost_arb_in; // [R12]
            transmit_error_status <= acc_bus_err || tx_bus_err_in; // [R13]
        end else begin
            if (request_set) begin
                aborted_status <= 1'b0; // [R14]
                lost_arbitration_status <= 1'b0; // [R14]
                transmit_error_status <= 1'b0; // [R14]
            end
            if (wr_status && !reg_wdata_in[can_txq_pkg::STA_ABORTED]) begin
                aborted_status <= 1'b0; // [R14]
            end
            if (wr_status && !reg_wdata_in[can_txq_pkg::STA_LOST_ARB]) begin
                lost_arbitration_status <= 1'b0; // [R14]
            end
            if (wr_status && !reg_wdata_in[can_txq_pkg::STA_TX_ERROR]) begin
                transmit_error_status <= 1'b0; // [R14]
            end
        end
    end

    // sticky attempts exhausted flag, set beats a same-cycle clear
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            attempts_exhausted_flag <= 1'b0;
        end else if (exhausted && send_request_bit) begin
            attempts_exhausted_flag <= 1'b1; // [R16]
        end else if (wr_status && !reg_wdata_in[can_txq_pkg::STA_ATTEMPTS_FLAG]) begin
            attempts_exhausted_flag <= 1'b0; // [R16]
        end
    end

    // head address follows the head pointer one cycle later; not meaningful in configuration
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            queue_head_address <= can_txq_pkg::WORD_RESET;
        end else begin
            // widened before the product so a far slot does not wrap at eight bits
            queue_head_address <= ram_base_in
                + {19'h00000, 13'(head_index) * 13'(slot_bytes_in)}; // [R19]
        end
    end

    // register read port
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reg_rdata_out <= can_txq_pkg::WORD_RESET;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_read_in;
            if (!reg_read_in) begin
                reg_rdata_out <= reg_rdata_out;
            end else if (reg_sel_in == can_txq_pkg::SEL_CONTROL) begin
                reg_rdata_out <= can_txq_pkg::WORD_RESET;
                reg_rdata_out[can_txq_pkg::CTL_RETRY_LSB +: 2] <= retry_attempts_field;
                reg_rdata_out[can_txq_pkg::CTL_QUEUE_RESET] <= queue_reset_bit; // [R01]
                reg_rdata_out[can_txq_pkg::CTL_SEND_REQUEST] <= send_request_bit;
                reg_rdata_out[can_txq_pkg::CTL_TRANSMIT_DIR] <= 1'b1; // [R08]
                reg_rdata_out[can_txq_pkg::CTL_ATTEMPTS_IE] <= attempts_exhausted_irq_enable;
                reg_rdata_out[can_txq_pkg::CTL_EMPTY_IE] <= queue_empty_irq_enable;
                reg_rdata_out[can_txq_pkg::CTL_NOT_FULL_IE] <= queue_not_full_irq_enable;
            end else if (reg_sel_in == can_txq_pkg::SEL_STATUS) begin
                reg_rdata_out <= can_txq_pkg::WORD_RESET;
                reg_rdata_out[can_txq_pkg::STA_INDEX_LSB +: 5] <= next_transmit_index; // [R10]
                reg_rdata_out[can_txq_pkg::STA_ABORTED] <= aborted_status;
                reg_rdata_out[can_txq_pkg::STA_LOST_ARB] <= lost_arbitration_status;
                reg_rdata_out[can_txq_pkg::STA_TX_ERROR] <= transmit_error_status;
                reg_rdata_out[can_txq_pkg::STA_ATTEMPTS_FLAG] <= attempts_exhausted_flag;
                reg_rdata_out[can_txq_pkg::STA_EMPTY] <= queue_empty_flag; // [R17]
                reg_rdata_out[can_txq_pkg::STA_NOT_FULL] <= queue_not_full_flag; // [R18]
            end else if (reg_sel_in == can_txq_pkg::SEL_HEAD_ADDRESS) begin
                reg_rdata_out <= queue_head_address; // [R19]
            end else begin
                reg_rdata_out <= can_txq_pkg::WORD_RESET;
            end
        end
    end

    // towards the protocol engine and the interrupt combiner
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tx_pending_out <= 1'b0;
            abort_request_out <= 1'b0;
            tail_index_out <= can_txq_pkg::INDEX_RESET;
            irq_enabled_events_out <= 3'h0;
        end else begin
            tx_pending_out <= send_request_bit && !queue_empty_flag && !queue_reset_bit; // [R04]
            abort_request_out <= abort_pending || request_abort; // [R05]
            tail_index_out <= next_transmit_index;
            irq_enabled_events_out <= {
                attempts_exhausted_flag && attempts_exhausted_irq_enable,
                queue_empty_flag && queue_empty_irq_enable,
                queue_not_full_flag && queue_not_full_irq_enable
            }; // [R09]
        end
    end

endmodule

/* File: rtl/can_txq_pkg.sv */
// shared constants for the transmit queue control and status block
package can_txq_pkg;

    // register selects on the register port
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_STATUS = 2'h1;
    localparam logic [1:0] SEL_HEAD_ADDRESS = 2'h2;

    // control register fields
    localparam int CTL_RETRY_LSB = 21;
    localparam int CTL_QUEUE_RESET = 10;
    localparam int CTL_SEND_REQUEST = 9;
    localparam int CTL_HEAD_INCREMENT = 8;
    localparam int CTL_TRANSMIT_DIR = 7;
    localparam int CTL_ATTEMPTS_IE = 4;
    localparam int CTL_EMPTY_IE = 2;
    localparam int CTL_NOT_FULL_IE = 0;

    // status register fields
    localparam int STA_INDEX_LSB = 8;
    localparam int STA_ABORTED = 7;
    localparam int STA_LOST_ARB = 6;
    localparam int STA_TX_ERROR = 5;
    localparam int STA_ATTEMPTS_FLAG = 4;
    localparam int STA_EMPTY = 2;
    localparam int STA_NOT_FULL = 0;

    // reset values
    localparam logic [1:0] RETRY_FIELD_RESET = 2'h3;
    localparam logic [4:0] INDEX_RESET = 5'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // retry field encodings
    localparam logic [1:0] RETRY_NONE = 2'h0;
    localparam logic [1:0] RETRY_THREE = 2'h1;

    // failed attempts that exhaust a message in each limited mode
    localparam logic [2:0] FAILS_NO_RETRY = 3'h1;
    localparam logic [2:0] FAILS_THREE_RETRY = 3'h4;

    // queue reset sequencing
    typedef enum logic {
        Q_RUN = 1'b0,
        Q_RESET = 1'b1
    } queue_state_t;

endpackage

/* File: rtl/txq_pointers.sv */
// head and tail pointers of the transmit queue, with occupancy flags
module txq_pointers (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic clear_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [4:0] depth_field_in,
    output logic [4:0] head_index_out,
    output logic [4:0] tail_index_out,
    output logic empty_out,
    output logic not_full_out,
    output logic last_one_out
);

    logic [5:0] count;
    logic [5:0] depth;
    logic do_push;
    logic do_pop;
    logic [5:0] next_count;

    // depth field is slots minus one
    assign depth = {1'b0, depth_field_in} + 6'h01;
    // a push into a full queue or a pop from an empty one is dropped
    assign do_push = push_in && (count < depth);
    assign do_pop = pop_in && (count != 6'h00);

    function automatic logic [4:0] wrap_next(input logic [4:0] idx, input logic [4:0] lim);
        wrap_next = (idx >= lim) ? 5'h00 : idx + 5'h01;
    endfunction

    always_comb begin
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + 6'h01;
        end else if (do_pop && !do_push) begin
            next_count = count - 6'h01;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in || clear_in) begin
            head_index_out <= can_txq_pkg::INDEX_RESET;
            tail_index_out <= can_txq_pkg::INDEX_RESET;
            count <= 6'h00;
        end else begin
            if (do_push) begin
                head_index_out <= wrap_next(head_index_out, depth_field_in); // [R07]
            end
            if (do_pop) begin
                tail_index_out <= wrap_next(tail_index_out, depth_field_in);
            end
            count <= next_count;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in || clear_in) begin
            empty_out <= 1'b1;
            not_full_out <= 1'b1;
            last_one_out <= 1'b0;
        end else begin
            empty_out <= (next_count == 6'h00); // [R22]
            not_full_out <= (next_count < depth); // [R22]
            last_one_out <= (next_count == 6'h01);
        end
    end

endmodule

/* File: tb/can_transmit_queue_ctrl_status_test.sv */
// self-checking bench for the transmit queue control block
module can_transmit_queue_ctrl_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] DEPTH_FIELD = 5'h03;
    localparam int SLOTS = DEPTH_FIELD + 1;
    logic mclk_in = 1'b0, rst_in = 1'b1, config_mode_in = 1'b1, global_retry_enable_in = 1'b1;
    logic reg_write_in = 1'b0, reg_read_in = 1'b0;
    logic [1:0] reg_sel_in = 2'h0, fail_mode = 2'h0;
    logic [31:0] reg_wdata_in = 32'h0, ram_base_in = 32'h0, rd_word, ie;
    logic [7:0] slot_bytes_in = 8'h0, gap = 8'h4;
    logic tx_success_in, tx_lost_arb_in, tx_bus_err_in, tx_aborted_in;
    logic [31:0] reg_rdata_out;
    logic reg_rvalid_out, tx_pending_out, abort_request_out;
    logic [4:0] tail_index_out;
    logic [2:0] irq_enabled_events_out;
    int error_cnt = 0, compares = 0, cycles = 0, seed = 98398;
    int head = 0, tail = 0, cnt = 0, req = 0, abt = 0, larb = 0, terr = 0, exh = 0, retry = 3;
    always #12.5 mclk_in = ~mclk_in;
    can_txq_ctrl dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .config_mode_in(config_mode_in),
        .global_retry_enable_in(global_retry_enable_in), .queue_depth_field_in(DEPTH_FIELD),
        .ram_base_in(ram_base_in), .slot_bytes_in(slot_bytes_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_sel_in(reg_sel_in), .reg_wdata_in(reg_wdata_in),
        .tx_success_in(tx_success_in), .tx_lost_arb_in(tx_lost_arb_in),
        .tx_bus_err_in(tx_bus_err_in), .tx_aborted_in(tx_aborted_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .tx_pending_out(tx_pending_out), .abort_request_out(abort_request_out),
        .tail_index_out(tail_index_out), .irq_enabled_events_out(irq_enabled_events_out));
    txq_engine_model engine_u (.mclk_in(mclk_in), .rst_in(rst_in), .pending_in(tx_pending_out),
        .abort_req_in(abort_request_out), .fail_mode_in(fail_mode), .gap_in(gap),
        .success_out(tx_success_in), .lost_arb_out(tx_lost_arb_in),
        .bus_err_out(tx_bus_err_in), .aborted_out(tx_aborted_in));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic access(input logic wr, input logic [1:0] sel, input logic [31:0] data);
        @(posedge mclk_in);
        reg_write_in <= wr;
        reg_read_in <= !wr;
        reg_sel_in <= sel;
        reg_wdata_in <= data;
        @(posedge mclk_in);
        reg_write_in <= 1'b0;
        reg_read_in <= 1'b0;
        #1;
        rd_word = reg_rdata_out;
        if (!wr) check("read valid", {31'h0, reg_rvalid_out}, 32'h1);
    endtask
    function automatic logic [31:0] exp_ctl(input logic [31:0] extra);
        return (32'(retry) << 21) | (32'(req) << 9) | 32'h80 | ie | extra;
    endfunction
    // host keeps off the queue until the selected self-clearing bit drops
    task automatic wait_clear(input int b);
        for (int i = 0; i < 300; i++) begin
            access(1'b0, can_txq_pkg::SEL_CONTROL, 32'h0);
            if (rd_word[b] === 1'b0) break;
        end
    endtask
    task automatic check_all();
        access(1'b0, can_txq_pkg::SEL_STATUS, 32'h0);
        check("status", rd_word, {19'h0, 5'(tail), abt[0], larb[0], terr[0], exh[0], 1'b0,
            cnt == 0, 1'b0, cnt < SLOTS});
        access(1'b0, can_txq_pkg::SEL_CONTROL, 32'h0);
        check("control", rd_word, exp_ctl(32'h0));
        access(1'b0, can_txq_pkg::SEL_HEAD_ADDRESS, 32'h0);
        check("head address", rd_word, ram_base_in + 32'(head) * 32'(slot_bytes_in));
        check("pending", 32'(tx_pending_out), 32'(req != 0 && cnt != 0));
        check("next index", 32'(tail_index_out), 32'(tail));
        check("irq events", 32'(irq_enabled_events_out),
            {29'h0, exh[0] & ie[4], cnt == 0 && ie[2], cnt < SLOTS && ie[0]});
    endtask
    task automatic send(input logic [1:0] mode, input logic [7:0] g);
        fail_mode <= mode;
        gap <= g;
        req = 1;
        {abt, larb, terr} = 0;
        access(1'b1, can_txq_pkg::SEL_CONTROL, exp_ctl(32'h0));
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        ram_base_in <= $random(seed) & 32'hffff_ff00;
        slot_bytes_in <= 8'($random(seed));
        ie = $random(seed) & 32'h15;
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        access(1'b0, can_txq_pkg::SEL_CONTROL, 32'h0);
        check("config control", rd_word, 32'h0060_0480);
        for (int c = 0; c < 4; c++) begin
            retry = (c + 2) % 4;
            access(1'b1, can_txq_pkg::SEL_CONTROL, exp_ctl(32'h0));
            access(1'b0, can_txq_pkg::SEL_CONTROL, 32'h0);
            check("retry field", rd_word, exp_ctl(32'h400));
        end
        @(posedge mclk_in);
        config_mode_in <= 1'b0;
        wait_clear(10);
        check_all();
        access(1'b0, 2'h3, 32'h0);
        check("unmapped", rd_word, 32'h0);
        for (int n = 0; n <= SLOTS; n++) begin
            access(1'b1, can_txq_pkg::SEL_CONTROL, exp_ctl(32'h100));
            if (cnt < SLOTS) begin
                cnt++;
                head = (head + 1) % SLOTS;
            end
            check_all();
        end
        send(2'h0, 8'(3 + ($random(seed) & 3)));
        wait_clear(9);
        {req, cnt, tail} = {32'h0, 32'h0, 32'(head)};
        check_all();
        access(1'b1, can_txq_pkg::SEL_CONTROL, exp_ctl(32'h100));
        {cnt, head} = {32'h1, 32'((head + 1) % SLOTS)};
        send(2'h1, 8'h3);
        wait_clear(9);
        {req, abt, larb, exh} = {32'h0, 32'h1, 32'h1, 32'h1};
        check_all();
        access(1'b1, can_txq_pkg::SEL_STATUS, 32'h0);
        {abt, larb, exh} = 0;
        check_all();
        @(posedge mclk_in);
        global_retry_enable_in <= 1'b0;
        send(2'h2, 8'd40);
        wait_clear(9);
        {req, abt, terr, exh} = {32'h0, 32'h1, 32'h1, 32'h1};
        check_all();
        send(2'h2, 8'd40);
        check_all();
        req = 0;
        access(1'b1, can_txq_pkg::SEL_CONTROL, exp_ctl(32'h0));
        check("abort request", 32'(abort_request_out), 32'h1);
        wait_clear(9);
        abt = 1;
        check_all();
        access(1'b1, can_txq_pkg::SEL_STATUS, 32'h0);
        access(1'b1, can_txq_pkg::SEL_CONTROL, exp_ctl(32'h400));
        wait_clear(10);
        {head, tail, cnt, abt, exh} = 0;
        check_all();
        give_verdict();
    end
endmodule

/* File: tb/can_txq_ctrl_sva.sv */
// port assertions for the transmit queue control block
module can_txq_ctrl_sva (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [4:0] queue_depth_field_in,
    input wire logic reg_read_in,
    input wire logic [1:0] reg_sel_in,
    input wire logic tx_aborted_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic tx_pending_out,
    input wire logic abort_request_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    sequence rd_seq(logic [1:0] s);
        reg_read_in && reg_sel_in == s;
    endsequence
    a_read_gets_valid: assert property (reg_read_in |=> reg_rvalid_out)
        else $error("read strobe without valid");
    a_valid_needs_read: assert property (!reg_read_in |=> !reg_rvalid_out)
        else $error("valid without read strobe");
    a_unmapped_reads_zero: assert property (rd_seq(2'h3) |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_dir_bit_one: assert property (rd_seq(can_txq_pkg::SEL_CONTROL) |=>
        reg_rdata_out[7] && !reg_rdata_out[8] && reg_rdata_out[15:11] == 5'h0)
        else $error("control read bits wrong");
    a_status_spare_zero: assert property (rd_seq(can_txq_pkg::SEL_STATUS) |=>
        reg_rdata_out[31:13] == 19'h0 && !reg_rdata_out[3] && !reg_rdata_out[1])
        else $error("status spare bits set");
    a_empty_not_full: assert property (rd_seq(can_txq_pkg::SEL_STATUS) |=>
        !reg_rdata_out[2] || reg_rdata_out[0])
        else $error("empty queue reads full");
    a_index_in_depth: assert property (rd_seq(can_txq_pkg::SEL_STATUS) |=>
        reg_rdata_out[12:8] <= queue_depth_field_in)
        else $error("index beyond depth");
    a_reset_quiet: assert property ($fell(rst_in) |->
        !tx_pending_out && !abort_request_out && !reg_rvalid_out)
        else $error("outputs active after reset");
    a_abort_drops_pending: assert property (tx_aborted_in && tx_pending_out |->
        ##2 !tx_pending_out)
        else $error("pending after abort");
    a_abort_request_ends: assert property (tx_aborted_in && abort_request_out |->
        ##2 !abort_request_out)
        else $error("abort request stuck");
    cover property (tx_aborted_in && abort_request_out);
    cover property (rd_seq(2'h3));
    cover property ($fell(tx_pending_out));
endmodule
bind can_txq_ctrl can_txq_ctrl_sva chk_u (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .queue_depth_field_in(queue_depth_field_in),
    .reg_read_in(reg_read_in),
    .reg_sel_in(reg_sel_in),
    .tx_aborted_in(tx_aborted_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out),
    .tx_pending_out(tx_pending_out),
    .abort_request_out(abort_request_out)
);

/* File: tb/txq_engine_model.sv */
// behavioural transmit engine answering the queue's send requests
module txq_engine_model (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic pending_in,
    input wire logic abort_req_in,
    input wire logic [1:0] fail_mode_in,
    input wire logic [7:0] gap_in,
    output logic success_out = 1'b0,
    output logic lost_arb_out = 1'b0,
    output logic bus_err_out = 1'b0,
    output logic aborted_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_cnt = 8'h0;
    logic fire;
    // gap of three or more keeps a stale pending level from causing a second pulse
    assign fire = pending_in && wait_cnt == gap_in;
    always @(posedge mclk_in) begin
        if (rst_in || !pending_in || fire) begin
            wait_cnt <= 8'h0;
        end else begin
            wait_cnt <= wait_cnt + 8'h1;
        end
        success_out <= !rst_in && fire && !abort_req_in && fail_mode_in == 2'h0;
        lost_arb_out <= !rst_in && fire && !abort_req_in && fail_mode_in == 2'h1;
        bus_err_out <= !rst_in && fire && !abort_req_in && fail_mode_in == 2'h2;
        aborted_out <= !rst_in && fire && abort_req_in;
    end
endmodule
